// ==== core/msb_map.svh ====
/*
  Register offsets, field positions, reset values and limits of the modulation source.
  Assumes it is included by its bare name from files under core/.
*/
// Notes on behaviour
// (R1) Sweep uses ramp (linear) or exponential (log); ramp direction follows stop versus start.
// (R2) Each trigger in triggered sweep starts exactly one modulation waveform cycle.
// (R3) FSK modulates with a 0/+1 square wave timed by the internal rate generator.
// (R4) FSK deviation is hop minus carrier, negative when hop is lower.
// (R5) With external FSK selected the internal rate generator is ignored.
// (R6) External FSK low selects carrier, high selects hop; sender holds valid levels.
// (R7) Each burst trigger emits exactly the configured number of whole carrier cycles.
// (R8) Phase zero is the first memory point; idle output holds the start phase sample.
// (R9) Burst never alters the dc offset, which is added after the waveform path.
// (R10) Gated burst: carrier runs while gate high; converter input forced zero asynchronously.
// (R11) Gated burst ignores burst count, rate and phase.
// (R12) Triggered burst gate follows the carrier and halts address advance at the end.
// (R13) Bursts paced by internal rate generator, or by external trigger when selected.
// (R14) Changing burst count, rate, phase or carrier flags a modulation RAM reload.
// (R15) Minimum burst count is 1 up to 1 MHz, one more per MHz band, 5 at 5 MHz.
// (R16) Modulation waveform holds 2048 to 4096 points in its own RAM.
// (R17) Arbitrary shapes are resized by interpolation, standard ones by decimation.
// (R18) Modulation changes reload only modulation RAM, never main waveform memory.
// (R19) AM uses an 8-bit sample; FM keeps 12-bit frequency resolution.
// (R20) Prescaler is k over modulation frequency, truncated, at least one.
// (R21) Points equal 2C over (1+S)F, rounded down to even.
// (R22) Modulation frequency accepted from 10 mHz to 20 kHz (AM) or 10 kHz (FM).
// (R23) External trigger and FSK select are synchronised; burst gate stays asynchronous.
`ifndef MSB_MAP_SVH
`define MSB_MAP_SVH

`define MSB_A_CTRL     8'h00
`define MSB_A_PRESC    8'h04
`define MSB_A_POINTS   8'h08
`define MSB_A_MODFREQ  8'h0C
`define MSB_A_BCOUNT   8'h10
`define MSB_A_BRATE    8'h14
`define MSB_A_BPHASE   8'h18
`define MSB_A_CARRIER  8'h1C
`define MSB_A_HOP      8'h20
`define MSB_A_START    8'h24
`define MSB_A_STOP     8'h28
`define MSB_A_FSKRATE  8'h2C
`define MSB_A_RAMADDR  8'h30
`define MSB_A_RAMDATA  8'h34
`define MSB_A_STATUS   8'h38
`define MSB_A_BUSTRIG  8'h3C

`define MSB_CTRL_MODE_HI  2
`define MSB_CTRL_MODE_LO  0
`define MSB_CTRL_FSK_EXT  3
`define MSB_CTRL_TRIG_EXT 4
`define MSB_CTRL_LOG      5
`define MSB_CTRL_SW_TRIG  6
`define MSB_ST_RELOAD     0
`define MSB_ST_RANGE_ERR  1
`define MSB_ST_BUSY       2

`define MSB_PTS_MIN    13'h0800
`define MSB_PTS_MAX    13'h1000
`define MSB_PRESC_MAX  21'h100000
`define MSB_FREQ_MIN   32'h0000000A
`define MSB_AM_FMAX    32'h01312D00
`define MSB_FM_FMAX    32'h00989680
`define MSB_BAND_1M    32'h000F4240
`define MSB_BAND_2M    32'h001E8480
`define MSB_BAND_3M    32'h002DC6C0
`define MSB_BAND_4M    32'h003D0900
`define MSB_RST_PRESC  21'h000001
`define MSB_RST_POINTS 13'h1000
`define MSB_RST_RATE   32'h0003D090
`define MSB_RST_BCOUNT 20'h00001

`endif

// ==== core/msb_pkg.sv ====
/*
  Types shared by the modulation source.
  Assumes msb_map.svh is available beside it.
*/
package msb_pkg;
  typedef enum logic [2:0] {
    MSB_MODE_OFF   = 3'h0,
    MSB_MODE_AM    = 3'h1,
    MSB_MODE_FM    = 3'h2,
    MSB_MODE_SWEEP = 3'h3,
    MSB_MODE_FSK   = 3'h4,
    MSB_MODE_BTRIG = 3'h5,
    MSB_MODE_BGATE = 3'h6
  } msb_mode_t;

  typedef enum logic [1:0] {
    MSB_ST_IDLE = 2'b00,
    MSB_ST_RUN  = 2'b01,
    MSB_ST_END  = 2'b11
  } msb_state_t;
endpackage

// ==== core/msb_mod_source.sv ====
/*
  Modulation source: modulation RAM, point clock, sweep, FSK and burst steering.
  Assumes a plain register port on ref_clk_in, a carrier generator that pulses
  carrier_wrap_in on the same clock at each carrier cycle end, and external TTL
  pins for trigger, FSK select and burst gate.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msb_map.svh"

module msb_mod_source
  import msb_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        ext_trig_in,
  input  wire logic        ext_fsk_in,
  input  wire logic        burst_gate_in,
  input  wire logic        carrier_wrap_in,
  output logic      [11:0] mod_sample_out,
  output logic      [7:0]  am_sample_out,
  output logic      [11:0] fm_sample_out,
  output logic             fsk_hop_out,
  output logic      [31:0] deviation_out,
  output logic             addr_run_out,
  output logic      [11:0] start_phase_out,
  output logic             dac_zero_out,
  output logic             sweep_log_out,
  output logic             sweep_down_out
);

  typedef struct packed {
    logic [6:0]  ctrl;
    logic [20:0] presc;
    logic [12:0] points;
    logic [31:0] modfreq;
    logic [19:0] bcount;
    logic [31:0] brate;
    logic [11:0] bphase;
    logic [31:0] carrier;
    logic [31:0] hop;
    logic [31:0] start;
    logic [31:0] stop;
    logic [31:0] fskrate;
    logic [11:0] ramaddr;
    logic [2:0]  status;
    logic [31:0] rdata;
    logic [2:0]  trig_sync;
    logic        trig_filt;
    logic        trig_prev;
    logic [2:0]  fsk_sync;
    logic        fsk_filt;
    logic [20:0] pre_cnt;
    logic [11:0] pt_addr;
    logic [31:0] brate_cnt;
    logic [31:0] fsk_cnt;
    logic        fsk_int;
    logic [19:0] cyc_cnt;
    msb_state_t  state;
    logic [11:0] sample;
  } msb_state_reg_t;

  msb_state_reg_t s_reg;
  msb_state_reg_t s_next;
  // Separate from main waveform memory; only written through the port below
  logic [11:0] mod_ram [0:4095];  // see (R16) (R18)
  logic        ram_we;
  logic [11:0] ram_rd;

  msb_mode_t mode;
  logic      pt_tick;
  logic      last_pt;
  logic      ext_rise;
  logic      trig_any;
  logic      burst_trig;
  logic [19:0] min_count;
  logic [19:0] eff_count;
  logic [31:0] fmax;

  assign mode = msb_mode_t'(s_reg.ctrl[`MSB_CTRL_MODE_HI:`MSB_CTRL_MODE_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // Modulation RAM

  always_ff @(posedge ref_clk_in) begin
    if (ram_we) begin
      mod_ram[s_reg.ramaddr] <= wdata_in[11:0];  // see (R17)
    end
    ram_rd <= mod_ram[s_reg.pt_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived terms

  always_comb begin
    if (s_reg.carrier > `MSB_BAND_4M) begin
      min_count = 20'h00005;  // see (R15)
    end else if (s_reg.carrier > `MSB_BAND_3M) begin
      min_count = 20'h00004;
    end else if (s_reg.carrier > `MSB_BAND_2M) begin
      min_count = 20'h00003;
    end else if (s_reg.carrier > `MSB_BAND_1M) begin
      min_count = 20'h00002;
    end else begin
      min_count = 20'h00001;
    end
    eff_count = (s_reg.bcount < min_count) ? min_count : s_reg.bcount;
    fmax      = (mode == MSB_MODE_AM) ? `MSB_AM_FMAX : `MSB_FM_FMAX;
  end

  assign pt_tick  = (s_reg.pre_cnt >= s_reg.presc);
  assign last_pt  = (s_reg.pt_addr == 12'(s_reg.points - 13'h0001));
  assign ext_rise = s_reg.trig_filt & ~s_reg.trig_prev;
  assign ram_we   = wr_in && (addr_in == `MSB_A_RAMDATA);
  // External trigger when selected; else bus trigger in sweep and internal rate generator pacing bursts
  assign trig_any = s_reg.ctrl[`MSB_CTRL_TRIG_EXT] ? ext_rise
                  : (wr_in && (addr_in == `MSB_A_BUSTRIG));  // see (R2)
  assign burst_trig = s_reg.ctrl[`MSB_CTRL_TRIG_EXT] ? ext_rise
                    : (s_reg.brate_cnt == 32'h00000000);  // see (R13)

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next       = s_reg;
    s_next.rdata = 32'h00000000;

    // Three stages; a change counts once stages two and three agree
    s_next.trig_sync = {s_reg.trig_sync[1:0], ext_trig_in};  // see (R23)
    s_next.fsk_sync  = {s_reg.fsk_sync[1:0], ext_fsk_in};
    if (s_reg.trig_sync[1] == s_reg.trig_sync[2]) begin
      s_next.trig_filt = s_reg.trig_sync[2];
    end
    if (s_reg.fsk_sync[1] == s_reg.fsk_sync[2]) begin
      s_next.fsk_filt = s_reg.fsk_sync[2];
    end
    s_next.trig_prev = s_reg.trig_filt;

    // Rate generators, periods in clocks; a write restarts the period at once
    s_next.brate_cnt = (s_reg.brate_cnt == 32'h00000000) ? s_reg.brate : s_reg.brate_cnt - 32'h00000001;
    if (s_reg.fsk_cnt <= 32'h00000001) begin
      s_next.fsk_cnt = s_reg.fskrate;
      s_next.fsk_int = ~s_reg.fsk_int;  // see (R3)
    end else begin
      s_next.fsk_cnt = s_reg.fsk_cnt - 32'h00000001;
    end

    if (wr_in) begin
      case (addr_in)
        `MSB_A_CTRL: begin
          s_next.ctrl = wdata_in[6:0];
        end
        `MSB_A_PRESC: begin
          if (wdata_in[20:0] == 21'h000000) begin
            s_next.presc = `MSB_RST_PRESC;  // see (R20)
          end else if (wdata_in[31:0] > 32'(`MSB_PRESC_MAX)) begin
            s_next.presc = `MSB_PRESC_MAX;
          end else begin
            s_next.presc = wdata_in[20:0];
          end
        end
        `MSB_A_POINTS: begin
          if (wdata_in[31:0] < 32'(`MSB_PTS_MIN)) begin
            s_next.points = `MSB_PTS_MIN;  // see (R16)
          end else if (wdata_in[31:0] > 32'(`MSB_PTS_MAX)) begin
            s_next.points = `MSB_PTS_MAX;
          end else begin
            s_next.points = {wdata_in[12:1], 1'b0};  // see (R21)
          end
        end
        `MSB_A_MODFREQ: begin
          if (wdata_in < `MSB_FREQ_MIN || wdata_in > fmax) begin
            s_next.status[`MSB_ST_RANGE_ERR] = 1'b1;  // see (R22)
          end else begin
            s_next.modfreq = wdata_in;
            s_next.status[`MSB_ST_RELOAD] = 1'b1;  // see (R18)
          end
        end
        `MSB_A_BCOUNT: begin
          s_next.bcount = wdata_in[19:0];
          s_next.status[`MSB_ST_RELOAD] = 1'b1;  // see (R14)
        end
        `MSB_A_BRATE: begin
          s_next.brate = wdata_in;
          s_next.brate_cnt = wdata_in;  // see (R13)
          s_next.status[`MSB_ST_RELOAD] = 1'b1;  // see (R14)
        end
        `MSB_A_BPHASE: begin
          s_next.bphase = wdata_in[11:0];
          s_next.status[`MSB_ST_RELOAD] = 1'b1;  // see (R14)
        end
        `MSB_A_CARRIER: begin
          s_next.carrier = wdata_in;
          s_next.status[`MSB_ST_RELOAD] = 1'b1;  // see (R14)
        end
        `MSB_A_HOP: begin
          s_next.hop = wdata_in;
        end
        `MSB_A_START: begin
          s_next.start = wdata_in;
        end
        `MSB_A_STOP: begin
          s_next.stop = wdata_in;
        end
        `MSB_A_FSKRATE: begin
          s_next.fskrate = wdata_in;
          s_next.fsk_cnt = wdata_in;  // see (R3)
        end
        `MSB_A_RAMADDR: begin
          s_next.ramaddr = wdata_in[11:0];
        end
        `MSB_A_RAMDATA: begin
          s_next.ramaddr = s_reg.ramaddr + 12'h001;
        end
        `MSB_A_STATUS: begin
          // Write one to clear; busy is hardware-owned
          s_next.status[1:0] = s_reg.status[1:0] & ~wdata_in[1:0];
        end
        default: begin
        end
      endcase
    end

    if (rd_in) begin
      case (addr_in)
        `MSB_A_CTRL:    s_next.rdata = {25'h0000000, s_reg.ctrl};
        `MSB_A_PRESC:   s_next.rdata = {11'h000, s_reg.presc};
        `MSB_A_POINTS:  s_next.rdata = {19'h00000, s_reg.points};
        `MSB_A_MODFREQ: s_next.rdata = s_reg.modfreq;
        `MSB_A_BCOUNT:  s_next.rdata = {12'h000, eff_count};
        `MSB_A_BRATE:   s_next.rdata = s_reg.brate;
        `MSB_A_BPHASE:  s_next.rdata = {20'h00000, s_reg.bphase};
        `MSB_A_CARRIER: s_next.rdata = s_reg.carrier;
        `MSB_A_HOP:     s_next.rdata = s_reg.hop;
        `MSB_A_START:   s_next.rdata = s_reg.start;
        `MSB_A_STOP:    s_next.rdata = s_reg.stop;
        `MSB_A_FSKRATE: s_next.rdata = s_reg.fskrate;
        `MSB_A_RAMADDR: s_next.rdata = {20'h00000, s_reg.ramaddr};
        `MSB_A_STATUS:  s_next.rdata = {29'h00000000, s_reg.status};
        default:        s_next.rdata = 32'h00000000;
      endcase
    end

    s_next.pre_cnt = pt_tick ? 21'h000000 : s_reg.pre_cnt + 21'h000001;

    case (s_reg.state)
      MSB_ST_IDLE: begin
        s_next.pre_cnt = 21'h000000;
        s_next.cyc_cnt = 20'h00000;
        if (mode == MSB_MODE_BTRIG) begin
          s_next.pt_addr = s_reg.bphase;  // see (R8)
          if (burst_trig) begin
            s_next.state = MSB_ST_RUN;  // see (R7)
          end
        end else if (mode == MSB_MODE_SWEEP && s_reg.ctrl[`MSB_CTRL_SW_TRIG]) begin
          s_next.pt_addr = 12'h000;
          if (trig_any) begin
            s_next.state = MSB_ST_RUN;  // see (R2)
          end
        end else if (mode != MSB_MODE_OFF && mode != MSB_MODE_BGATE) begin
          s_next.state = MSB_ST_RUN;
        end
      end
      MSB_ST_RUN: begin
        if (mode == MSB_MODE_BTRIG) begin
          if (carrier_wrap_in) begin
            s_next.cyc_cnt = s_reg.cyc_cnt + 20'h00001;
            if (s_reg.cyc_cnt + 20'h00001 >= eff_count) begin
              s_next.state = MSB_ST_END;  // see (R12)
            end
          end
        end else if (mode == MSB_MODE_OFF || mode == MSB_MODE_BGATE) begin
          s_next.state = MSB_ST_IDLE;
        end else if (pt_tick) begin
          if (last_pt) begin
            s_next.pt_addr = 12'h000;
            if (mode == MSB_MODE_SWEEP && s_reg.ctrl[`MSB_CTRL_SW_TRIG]) begin
              s_next.state = MSB_ST_END;  // see (R2)
            end
          end else begin
            s_next.pt_addr = s_reg.pt_addr + 12'h001;
          end
        end
      end
      MSB_ST_END: begin
        s_next.state = MSB_ST_IDLE;
      end
      default: begin
        s_next.state = MSB_ST_IDLE;
      end
    endcase

    s_next.status[`MSB_ST_BUSY] = (s_reg.state != MSB_ST_IDLE);
    s_next.sample = ram_rd;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_reg         <= '0;
      s_reg.presc   <= `MSB_RST_PRESC;
      s_reg.points  <= `MSB_RST_POINTS;
      s_reg.brate   <= `MSB_RST_RATE;
      s_reg.fskrate <= `MSB_RST_RATE;
      s_reg.bcount  <= `MSB_RST_BCOUNT;
      s_reg.modfreq <= `MSB_FREQ_MIN;
      s_reg.state   <= MSB_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_out       = s_reg.rdata;
  assign mod_sample_out  = s_reg.sample;
  assign am_sample_out   = s_reg.sample[11:4];  // see (R19)
  assign fm_sample_out   = s_reg.sample;  // see (R19)
  // Ramp addresses always run upward; direction is flagged to the carrier path
  assign sweep_down_out  = (mode == MSB_MODE_SWEEP) && (s_reg.stop < s_reg.start);  // see (R1)
  assign sweep_log_out   = (mode == MSB_MODE_SWEEP) && s_reg.ctrl[`MSB_CTRL_LOG];  // see (R1)
  assign fsk_hop_out     = (mode == MSB_MODE_FSK)
                         && (s_reg.ctrl[`MSB_CTRL_FSK_EXT] ? s_reg.fsk_filt : s_reg.fsk_int);  // see (R5) (R6)
  assign deviation_out   = s_reg.hop - s_reg.carrier;  // see (R4)
  // Gated mode ignores count, rate and phase: gate alone steers the carrier
  assign addr_run_out    = (mode != MSB_MODE_BTRIG) || (s_reg.state == MSB_ST_RUN);  // see (R11) (R12)
  assign start_phase_out = s_reg.bphase;  // see (R8)
  // Combinational on the raw pin so the zeroing is immediate; offset path untouched
  assign dac_zero_out    = (mode == MSB_MODE_BGATE) && !burst_gate_in;  // see (R9) (R10)

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_burst_stops;  // see (R7)
    @(posedge ref_clk_in) disable iff (rst_in)
      (s_reg.state == MSB_ST_RUN && mode == MSB_MODE_BTRIG && carrier_wrap_in
       && s_reg.cyc_cnt + 20'h00001 >= eff_count) |=> !addr_run_out;
  endproperty
  a_burst_stops: assert property (p_burst_stops) else $error("burst overran count");  // see (R7)

  property p_idle_phase;  // see (R8)
    @(posedge ref_clk_in) disable iff (rst_in)
      (s_reg.state == MSB_ST_IDLE && mode == MSB_MODE_BTRIG && $stable(mode)) ##1
      (s_reg.state == MSB_ST_IDLE) |-> s_reg.pt_addr == $past(s_reg.bphase);
  endproperty
  a_idle_phase: assert property (p_idle_phase) else $error("idle address not start phase");  // see (R8)

  property p_gate_zero;  // see (R10)
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode == MSB_MODE_BGATE) |-> (dac_zero_out == !burst_gate_in);
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("gated zero wrong");  // see (R10)

  property p_gate_run;  // see (R11)
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode == MSB_MODE_BGATE) ##1 (mode == MSB_MODE_BGATE) |-> addr_run_out;
  endproperty
  a_gate_run: assert property (p_gate_run) else $error("gated mode halted address");  // see (R11)

  property p_reload_flag;  // see (R14)
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_in && (addr_in == `MSB_A_CARRIER || addr_in == `MSB_A_BCOUNT
       || addr_in == `MSB_A_BRATE || addr_in == `MSB_A_BPHASE)) |=> s_reg.status[`MSB_ST_RELOAD];
  endproperty
  a_reload_flag: assert property (p_reload_flag) else $error("reload flag not set");  // see (R14)

  property p_min_count;  // see (R15)
    @(posedge ref_clk_in) disable iff (rst_in)
      (s_reg.carrier > `MSB_BAND_4M) |-> eff_count >= 20'h00005;
  endproperty
  a_min_count: assert property (p_min_count) else $error("burst count below minimum");  // see (R15)

  property p_points_even;  // see (R21)
    @(posedge ref_clk_in) disable iff (rst_in)
      !s_reg.points[0] && s_reg.points >= `MSB_PTS_MIN && s_reg.points <= `MSB_PTS_MAX;
  endproperty
  a_points_even: assert property (p_points_even) else $error("point count out of range");  // see (R21)

  property p_presc_min;  // see (R20)
    @(posedge ref_clk_in) disable iff (rst_in)
      s_reg.presc != 21'h000000;
  endproperty
  a_presc_min: assert property (p_presc_min) else $error("prescaler zero");  // see (R20)

  property p_sweep_once;  // see (R2)
    @(posedge ref_clk_in) disable iff (rst_in)
      (s_reg.state == MSB_ST_END && mode == MSB_MODE_SWEEP) |=> s_reg.state == MSB_ST_IDLE ##1
      (s_reg.state == MSB_ST_IDLE || $past(trig_any));
  endproperty
  a_sweep_once: assert property (p_sweep_once) else $error("sweep restarted without trigger");  // see (R2)

  property p_fsk_ext;  // see (R6)
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode == MSB_MODE_FSK && s_reg.ctrl[`MSB_CTRL_FSK_EXT]) |-> fsk_hop_out == s_reg.fsk_filt;
  endproperty
  a_fsk_ext: assert property (p_fsk_ext) else $error("external FSK not followed");  // see (R6)

  property p_range;  // see (R22)
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_in && addr_in == `MSB_A_MODFREQ && wdata_in > `MSB_AM_FMAX) |=> $stable(s_reg.modfreq);
  endproperty
  a_range: assert property (p_range) else $error("out of range frequency accepted");  // see (R22)

endmodule  // msb_mod_source

`default_nettype wire

// ==== sim/msb_ttl_partner.sv ====
/*
  TTL-side partner of the modulation source: trigger, FSK select, burst gate and carrier wrap.
  Assumes the bench calls its tasks hierarchically and shares ref_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module msb_ttl_partner (
  input  wire logic ref_clk_in,
  output logic      ext_trig_out,
  output logic      ext_fsk_out,
  output logic      burst_gate_out,
  output logic      carrier_wrap_out
);
  logic [2:0] wrap_cnt_reg;

  initial begin
    ext_trig_out     = 1'b0;
    ext_fsk_out      = 1'b0;
    burst_gate_out   = 1'b0;
    carrier_wrap_out = 1'b0;
    wrap_cnt_reg     = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Carrier ends a cycle every 7 clocks; odd spacing keeps it off any trigger grid
  always @(posedge ref_clk_in) begin
    wrap_cnt_reg     <= (wrap_cnt_reg == 3'h6) ? 3'h0 : wrap_cnt_reg + 3'h1;
    carrier_wrap_out <= (wrap_cnt_reg == 3'h6);
  end

  ////////////////////////////////////////////////////////////////////////
  // Held for 6 clocks so the input filter cannot miss it
  task automatic pulse_trig();
    @(posedge ref_clk_in);
    ext_trig_out <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    ext_trig_out <= 1'b0;
  endtask

  // Level held until the next call, a valid TTL level for the whole interval
  task automatic set_fsk(input logic lvl);
    @(posedge ref_clk_in);
    ext_fsk_out <= lvl;
  endtask

  task automatic set_gate(input logic lvl);
    @(posedge ref_clk_in);
    burst_gate_out <= lvl;
  endtask
endmodule // msb_ttl_partner

`default_nettype wire

// ==== sim/modulation_source_burst_fsk_bench.sv ====
/*
  Self-checking bench of the modulation source: register port, FSK, sweep and burst steering.
  Assumes msb_ttl_partner drives the TTL pins and the carrier wrap pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module modulation_source_burst_fsk_bench
  import msb_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wdata_in   = 32'h0;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic [31:0] rdata_out, deviation_out, rd_val;
  logic        ext_trig, ext_fsk, gate, wrap;
  logic        fsk_hop_out, addr_run_out, dac_zero_out, sweep_log_out, sweep_down_out;
  logic [11:0] start_phase_out, mod_sample, fm_sample;
  logic [7:0]  am_sample;
  int          error_cnt = 0;
  int          comparisons = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  msb_mod_source i_msb_mod_source (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_trig_in(ext_trig),
    .ext_fsk_in(ext_fsk), .burst_gate_in(gate), .carrier_wrap_in(wrap),
    .mod_sample_out(mod_sample), .am_sample_out(am_sample), .fm_sample_out(fm_sample), .fsk_hop_out(fsk_hop_out),
    .deviation_out(deviation_out), .addr_run_out(addr_run_out), .start_phase_out(start_phase_out),
    .dac_zero_out(dac_zero_out), .sweep_log_out(sweep_log_out), .sweep_down_out(sweep_down_out));

  msb_ttl_partner i_msb_ttl_partner (
    .ref_clk_in(ref_clk_in), .ext_trig_out(ext_trig), .ext_fsk_out(ext_fsk),
    .burst_gate_out(gate), .carrier_wrap_out(wrap));

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout_chk(input int i, input int lim);
    if (i >= lim) begin
      error_cnt++;
      $display("[ERR] wait expected below %0d seen %0d", lim, i);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_val);
    chk(what, exp, rd_val);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_limits();
    rd_chk("prescaler reset", 8'h04, 32'h00000001);
    wr(8'h04, 32'h0);
    rd_chk("prescaler floor", 8'h04, 32'h00000001);
    wr(8'h08, 32'h00000100);
    rd_chk("points floor", 8'h08, 32'h00000800);
    wr(8'h08, 32'h00002000);
    rd_chk("points ceiling", 8'h08, 32'h00001000);
    wr(8'h08, 32'h00000901);
    rd_chk("points even", 8'h08, 32'h00000900);
    rd_chk("unmapped read", 8'h40, 32'h0);
    wr(8'h0C, 32'h01312D01);
    rd_chk("freq refused", 8'h0C, 32'h0000000A);
    // Mode is off, so the point address rests on entry zero
    wr(8'h34, 32'h00000ABC);
    rd_chk("ram addr step", 8'h30, 32'h00000001);
    chk("mod sample", 32'h00000ABC, {20'h0, mod_sample});
    chk("am sample", 32'h000000AB, {24'h0, am_sample});
    chk("fm sample", 32'h00000ABC, {20'h0, fm_sample});
  endtask

  task automatic t_burst_min();
    wr(8'h1C, 32'h002625A0);
    wr(8'h10, 32'h00000001);
    rd_chk("min count 2.5 MHz", 8'h10, 32'h00000003);
    rd(8'h38, rd_val);
    chk("reload pending", 32'h1, {31'h0, rd_val[0]});
    wr(8'h1C, 32'h003D0901);
    rd_chk("min count above 4 MHz", 8'h10, 32'h00000005);
  endtask

  task automatic t_fsk();
    logic lvl;
    int   i;
    wr(8'h2C, 32'h00000008);
    wr(8'h1C, 32'h000003E8);
    wr(8'h20, 32'h000001F4);
    #1 chk("deviation", 32'hFFFFFE0C, deviation_out);
    wr(8'h00, 32'h0000000C);
    i_msb_ttl_partner.set_fsk(1'b1);
    repeat (8) @(posedge ref_clk_in);
    chk("fsk high picks hop", 32'h1, {31'h0, fsk_hop_out});
    // The internal square wave toggles once in these 8 clocks
    repeat (8) @(posedge ref_clk_in);
    chk("fsk ignores rate", 32'h1, {31'h0, fsk_hop_out});
    i_msb_ttl_partner.set_fsk(1'b0);
    repeat (8) @(posedge ref_clk_in);
    chk("fsk low picks carrier", 32'h0, {31'h0, fsk_hop_out});
    wr(8'h00, 32'h00000004);
    #1 lvl = fsk_hop_out;
    for (i = 0; i < 20 && fsk_hop_out === lvl; i++) @(posedge ref_clk_in) #1;
    timeout_chk(i, 20);
    lvl = fsk_hop_out;
    for (i = 0; i < 20 && fsk_hop_out === lvl; i++) @(posedge ref_clk_in) #1;
    chk("fsk half period", 32'd8, i);
  endtask

  task automatic t_sweep();
    wr(8'h24, 32'h00001388);
    wr(8'h28, 32'h00000032);
    wr(8'h00, 32'h00000023);
    #1 chk("sweep log", 32'h1, {31'h0, sweep_log_out});
    chk("sweep down", 32'h1, {31'h0, sweep_down_out});
    wr(8'h00, 32'h00000003);
    #1 chk("sweep linear", 32'h0, {31'h0, sweep_log_out});
    wr(8'h08, 32'h00000800);
    wr(8'h00, 32'h00000000);
    wr(8'h00, 32'h00000043);
    wr(8'h3C, 32'h00000001);
    rd(8'h38, rd_val);
    chk("sweep runs", 32'h1, {31'h0, rd_val[2]});
    // 2048 points at two clocks each, then it must rest
    repeat (4200) @(posedge ref_clk_in);
    rd(8'h38, rd_val);
    chk("one sweep only", 32'h0, {31'h0, rd_val[2]});
  endtask

  task automatic t_burst_trig();
    int n;
    int i;
    n = 0;
    wr(8'h10, 32'h00000002);
    wr(8'h18, 32'h00000123);
    wr(8'h00, 32'h00000015);
    #1 chk("start phase", 32'h123, {20'h0, start_phase_out});
    chk("idle halts address", 32'h0, {31'h0, addr_run_out});
    fork
      i_msb_ttl_partner.pulse_trig();
    join_none
    for (i = 0; i < 50 && addr_run_out !== 1'b1; i++) @(posedge ref_clk_in);
    timeout_chk(i, 50);
    // Count the wraps sampled at each running edge, this one included
    for (i = 0; i < 300 && addr_run_out === 1'b1; i++) begin
      if (wrap === 1'b1) n++;
      @(posedge ref_clk_in);
    end
    timeout_chk(i, 300);
    chk("burst cycles", 32'd2, n);
    repeat (20) @(posedge ref_clk_in);
    chk("stays halted", 32'h0, {31'h0, addr_run_out});
    wr(8'h14, 32'h00000028);
    wr(8'h00, 32'h00000005);
    for (i = 0; i < 60 && addr_run_out !== 1'b1; i++) @(posedge ref_clk_in);
    timeout_chk(i, 60);
    chk("internal rate period", 32'd40, i);
  endtask

  task automatic t_gate();
    wr(8'h00, 32'h00000006);
    i_msb_ttl_partner.set_gate(1'b0);
    #1 chk("gate low zeroes", 32'h1, {31'h0, dac_zero_out});
    i_msb_ttl_partner.set_gate(1'b1);
    #1 chk("gate high runs", 32'h0, {31'h0, dac_zero_out});
    chk("gate ignores phase", 32'h1, {31'h0, addr_run_out});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1 chk("run after reset", 32'h1, {31'h0, addr_run_out});
    t_limits();
    t_burst_min();
    t_fsk();
    t_sweep();
    t_burst_trig();
    t_gate();
    print_verdict();
  end
endmodule // modulation_source_burst_fsk_bench

`default_nettype wire
